// *** core/nfpm_pkg.sv ***
package nfpm_pkg;
  localparam int WS_W = 5;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int EXT_W = 2;
  localparam int SEL_W = 2;
  localparam logic [4:0] WS_MAX = 5'h13;
  localparam logic [4:0] SETUP_DEFAULT = 5'h02;
  localparam logic [4:0] PULSE_DEFAULT = 5'h0B;
  localparam logic [4:0] HOLD_DEFAULT = 5'h02;
  localparam logic [4:0] ACCESS_DEFAULT = 5'h13;
  localparam logic [1:0] SEL_A = 2'h0;
  localparam logic [1:0] SEL_BOOT = 2'h1;
  localparam logic [1:0] SEL_C = 2'h2;
  localparam real WAIT_STATE_NS = 6.7;
  localparam real CLK_PERIOD_NS = 8.0;
  // One wait state is shorter than a clock, so each counts one clock
  localparam int WS_CYCLES = (WAIT_STATE_NS / CLK_PERIOD_NS) < 1.0 ? 1 :
                             int'(WAIT_STATE_NS / CLK_PERIOD_NS);
  typedef enum logic [2:0] {
    NFPM_IDLE, NFPM_SETUP, NFPM_PULSE, NFPM_HOLD, NFPM_ACCESS, NFPM_DONE
  } nfpm_state_type;
endpackage : nfpm_pkg

// *** core/nfpm_port.sv ***
`timescale 1ns/1ps
module nfpm_port (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic timing_load,
  input wire logic [4:0] setup_count,
  input wire logic [4:0] pulse_count,
  input wire logic [4:0] hold_count,
  input wire logic [4:0] access_count,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_select,
  input wire logic [23:0] req_addr,
  input wire logic [1:0] req_ext,
  input wire logic ext_enable,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  output logic resp_valid,
  output logic [15:0] resp_rdata,
  output logic prog_mem_select_a,
  output logic boot_mem_select,
  output logic prog_mem_select_c,
  output logic write_strobe_n,
  output logic [23:0] flash_addr,
  output logic [1:0] ext_addr_out,
  output logic [1:0] ext_addr_oe_n,
  output logic [15:0] flash_data_out,
  output logic flash_data_oe_n,
  input wire logic [15:0] flash_data_in
);
  nfpm_timing_if tim();
  nfpm_pkg::nfpm_state_type state;
  logic [4:0] count;
  logic is_write;
  logic [1:0] sel;
  logic take;

  nfpm_timing u_timing (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(timing_load),
    .setup_in(setup_count),
    .pulse_in(pulse_count),
    .hold_in(hold_count),
    .access_in(access_count),
    .tim(tim)
  );

  function automatic logic [2:0] nfpm_decode(input logic [1:0] s);
    case (s)
      nfpm_pkg::SEL_A: nfpm_decode = 3'h1;
      nfpm_pkg::SEL_BOOT: nfpm_decode = 3'h2;
      nfpm_pkg::SEL_C: nfpm_decode = 3'h4;
      default: nfpm_decode = 3'h0;
    endcase
  endfunction : nfpm_decode

  // A request is taken only in idle and only for a decoded select
  assign take = (state == nfpm_pkg::NFPM_IDLE) && req_valid &&
                (nfpm_decode(req_select) != 3'h0);

  // Transfer kind and select, held for the whole transfer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      is_write <= 1'b0;
      sel <= nfpm_pkg::SEL_BOOT;
    end else if (take) begin
      is_write <= req_write;
      sel <= req_select;
    end
  end

  // Sequencer; each wait state takes one clock
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= nfpm_pkg::NFPM_IDLE;
      count <= 5'h00;
    end else begin
      case (state)
        nfpm_pkg::NFPM_IDLE: begin
          if (take) begin
            count <= req_write ? tim.setup : tim.access;
            state <= req_write ? nfpm_pkg::NFPM_SETUP : nfpm_pkg::NFPM_ACCESS;
          end
        end
        nfpm_pkg::NFPM_SETUP: begin
          if (count == 5'h00) begin
            count <= tim.pulse;
            state <= nfpm_pkg::NFPM_PULSE;
          end else begin
            count <= count - 5'h01;
          end
        end
        nfpm_pkg::NFPM_PULSE: begin
          if (count <= 5'h01) begin
            count <= tim.hold;
            state <= nfpm_pkg::NFPM_HOLD;
          end else begin
            count <= count - 5'h01;
          end
        end
        nfpm_pkg::NFPM_HOLD: begin
          if (count == 5'h00) begin
            state <= nfpm_pkg::NFPM_DONE;
          end else begin
            count <= count - 5'h01;
          end
        end
        nfpm_pkg::NFPM_ACCESS: begin
          if (count == 5'h00) begin
            state <= nfpm_pkg::NFPM_DONE;
          end else begin
            count <= count - 5'h01;
          end
        end
        nfpm_pkg::NFPM_DONE: state <= nfpm_pkg::NFPM_IDLE;
        default: state <= nfpm_pkg::NFPM_IDLE;
      endcase
    end
  end

  // Chip selects, one at a time, released in reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prog_mem_select_a <= 1'b1;
      boot_mem_select <= 1'b1;
      prog_mem_select_c <= 1'b1;
    end else begin
      logic [2:0] hot;
      hot = 3'h0;
      case (state)
        nfpm_pkg::NFPM_IDLE: begin
          if (req_valid) begin
            hot = nfpm_decode(req_select);
          end
        end
        nfpm_pkg::NFPM_DONE: hot = 3'h0;
        default: hot = nfpm_decode(sel);
      endcase
      if (state == nfpm_pkg::NFPM_HOLD && count == 5'h00) begin
        hot = 3'h0;
      end
      if (state == nfpm_pkg::NFPM_ACCESS && count == 5'h00) begin
        hot = 3'h0;
      end
      prog_mem_select_a <= ~hot[0];
      boot_mem_select <= ~hot[1];
      prog_mem_select_c <= ~hot[2];
    end
  end

  // Write strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      write_strobe_n <= 1'b1;
    end else if (state == nfpm_pkg::NFPM_SETUP && count == 5'h00) begin
      write_strobe_n <= (tim.pulse == 5'h00);
    end else if (state == nfpm_pkg::NFPM_PULSE && count <= 5'h01) begin
      write_strobe_n <= 1'b1;
    end
  end

  // Address, extension pins and data bus
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flash_addr <= 24'h000000;
      ext_addr_out <= 2'h0;
      ext_addr_oe_n <= 2'h3;
      flash_data_out <= 16'h0000;
      flash_data_oe_n <= 1'b1;
    end else begin
      ext_addr_oe_n <= ext_enable ? 2'h0 : 2'h3;
      if (take) begin
        flash_addr <= req_addr;
        ext_addr_out <= req_ext;
        flash_data_out <= req_wdata;
        flash_data_oe_n <= ~req_write;
      end else if (state == nfpm_pkg::NFPM_DONE) begin
        flash_data_oe_n <= 1'b1;
      end
    end
  end

  // Transfer complete, one clock after the select is released
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state == nfpm_pkg::NFPM_DONE);
    end
  end

  // Read sample and response
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp_rdata <= 16'h0000;
    end else begin
      resp_valid <= 1'b0;
      if (state == nfpm_pkg::NFPM_ACCESS && count == 5'h00) begin
        resp_rdata <= flash_data_in;
        resp_valid <= 1'b1;
      end else if (state == nfpm_pkg::NFPM_HOLD && count == 5'h00) begin
        resp_valid <= 1'b1;
      end
      if (is_write) begin
        resp_rdata <= resp_rdata;
      end
    end
  end
endmodule : nfpm_port

// *** core/nfpm_timing.sv ***
`timescale 1ns/1ps
module nfpm_timing (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [4:0] setup_in,
  input wire logic [4:0] pulse_in,
  input wire logic [4:0] hold_in,
  input wire logic [4:0] access_in,
  nfpm_timing_if.source tim
);
  function automatic logic [4:0] nfpm_clamp(input logic [4:0] v);
    nfpm_clamp = (v > nfpm_pkg::WS_MAX) ? nfpm_pkg::WS_MAX : v;
  endfunction : nfpm_clamp

  // Wait-state counts, limited to the maximum
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tim.setup <= nfpm_pkg::SETUP_DEFAULT;
      tim.pulse <= nfpm_pkg::PULSE_DEFAULT;
      tim.hold <= nfpm_pkg::HOLD_DEFAULT;
      tim.access <= nfpm_pkg::ACCESS_DEFAULT;
    end else if (load) begin
      tim.setup <= nfpm_clamp(setup_in);
      tim.pulse <= nfpm_clamp(pulse_in);
      tim.hold <= nfpm_clamp(hold_in);
      tim.access <= nfpm_clamp(access_in);
    end
  end
endmodule : nfpm_timing

// *** core/nfpm_timing_if.sv ***
`timescale 1ns/1ps
interface nfpm_timing_if;
  logic [4:0] setup;
  logic [4:0] pulse;
  logic [4:0] hold;
  logic [4:0] access;
  modport source (output setup, output pulse, output hold, output access);
  modport sink (input setup, input pulse, input hold, input access);
endinterface : nfpm_timing_if

// *** test/nfpm_flash_model.sv ***
`timescale 1ns/1ps
module nfpm_flash_model (
  input wire logic ref_clk,
  input wire logic [2:0] sel_n,
  input wire logic write_strobe_n,
  input wire logic [23:0] flash_addr,
  input wire logic [15:0] flash_data_out,
  input wire logic [4:0] delay,
  output logic [15:0] flash_data_in
);
  logic [15:0] mem [0:15];
  logic [15:0] last = 16'h0;
  logic [4:0] age = 5'h0;
  logic [1:0] id;
  assign id = !sel_n[0] ? 2'h0 : (!sel_n[1] ? 2'h1 : 2'h2);
  // Data only valid once the access time has run; otherwise a changing pattern
  assign flash_data_in = (sel_n != 3'h7 && write_strobe_n && age >= delay) ?
    mem[{id, flash_addr[1:0]}] : ~last;
  always @(posedge ref_clk) begin
    last <= flash_data_in;
    age <= (sel_n == 3'h7) ? 5'h0 : age + 5'h1;
  end
  always @(posedge write_strobe_n) begin
    if (sel_n != 3'h7) mem[{id, flash_addr[1:0]}] <= flash_data_out;
  end
endmodule : nfpm_flash_model

// *** test/nfpm_port_props.sv ***
`timescale 1ns/1ps
module nfpm_port_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [1:0] req_select,
  input wire logic resp_valid,
  input wire logic req_ready,
  input wire logic prog_mem_select_a,
  input wire logic boot_mem_select,
  input wire logic prog_mem_select_c,
  input wire logic write_strobe_n
);
  wire logic [2:0] s = {prog_mem_select_c, boot_mem_select, prog_mem_select_a};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  one_select_a: assert property ($countones(~s) < 2) else $error("two selects low");
  reset_idle_a: assert property (disable iff (1'b0) !rst_n |=> s == 3'h7 && write_strobe_n)
    else $error("select or strobe low after reset");
  strobe_inside_a: assert property (!write_strobe_n |-> s != 3'h7) else $error("bare strobe");
  setup_first_a: assert property ($fell(write_strobe_n) |-> $past(s) != 3'h7)
    else $error("strobe fell with select");
  hold_after_a: assert property ($rose(write_strobe_n) && $past(rst_n) |-> s != 3'h7)
    else $error("select released with strobe");
  resp_ready_a: assert property (resp_valid |=> req_ready && !resp_valid)
    else $error("ready not after response");
  boot_take_a: assert property ($fell(boot_mem_select) |-> $past(req_select) == 2'h1)
    else $error("boot select without boot request");
  first_take_a: assert property ($fell(prog_mem_select_a) |-> $past(req_valid)
    && $past(req_select) == 2'h0) else $error("first select without request");
endmodule : nfpm_port_props
bind nfpm_port nfpm_port_props props_u (.ref_clk(ref_clk), .rst_n(rst_n),
  .req_valid(req_valid), .req_select(req_select), .resp_valid(resp_valid),
  .req_ready(req_ready), .prog_mem_select_a(prog_mem_select_a),
  .boot_mem_select(boot_mem_select), .prog_mem_select_c(prog_mem_select_c),
  .write_strobe_n(write_strobe_n));

// *** test/nfpm_port_test.sv ***
`timescale 1ns/1ps
module nfpm_port_test;
  logic ref_clk = 1'b0, rst_n = 1'b0, timing_load = 1'b0, req_valid = 1'b0;
  logic req_write = 1'b0, ext_enable = 1'b0, pw = 1'b1;
  logic [4:0] su = 5'h0, pu = 5'h0, ho = 5'h0, ac = 5'h0, mdel = 5'h11;
  logic [1:0] req_select = 2'h0, ext_o, ext_oe, ext_seen, oe_seen;
  logic [23:0] fa, fa_seen;
  logic [15:0] req_wdata = 16'h0, resp_rdata, fdo, fdi, rd;
  logic req_ready, resp_valid, we_n, doe_n, a_n, b_n, c_n, doe_seen;
  logic [2:0] ps = 3'h7;
  int miscompares = 0, checked = 0, cyc = 0, tsf, twf, twr, tsr, trv, nsel = 0, s0, p0, h0, a0;
  wire logic [2:0] sel_n = {c_n, b_n, a_n};
  always #4 ref_clk = ~ref_clk;
  nfpm_port dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .timing_load(timing_load),
    .setup_count(su), .pulse_count(pu), .hold_count(ho), .access_count(ac),
    .req_valid(req_valid), .req_write(req_write), .req_select(req_select),
    .req_addr(24'hABCD02), .req_ext(2'h2), .ext_enable(ext_enable), .req_wdata(req_wdata),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .prog_mem_select_a(a_n), .boot_mem_select(b_n), .prog_mem_select_c(c_n),
    .write_strobe_n(we_n), .flash_addr(fa), .ext_addr_out(ext_o), .ext_addr_oe_n(ext_oe),
    .flash_data_out(fdo), .flash_data_oe_n(doe_n), .flash_data_in(fdi));
  nfpm_flash_model flash_u (.ref_clk(ref_clk), .sel_n(sel_n), .write_strobe_n(we_n),
    .flash_addr(fa), .flash_data_out(fdo), .delay(mdel), .flash_data_in(fdi));
  always @(negedge ref_clk) begin
    cyc = cyc + 1;
    if (ps == 3'h7 && sel_n != 3'h7) begin
      tsf = cyc;
      nsel = nsel + 1;
    end
    if (sel_n != 3'h7) {ext_seen, oe_seen, fa_seen, doe_seen} = {ext_o, ext_oe, fa, doe_n};
    if (pw && !we_n) twf = cyc;
    if (!pw && we_n) twr = cyc;
    if (ps != 3'h7 && sel_n == 3'h7) tsr = cyc;
    if (resp_valid === 1'b1) {trv, rd} = {cyc, resp_rdata};
    {ps, pw} = {sel_n, we_n};
  end
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask : cmp
  task load(input logic [4:0] s, input logic [4:0] p, input logic [4:0] h, input logic [4:0] a);
    @(posedge ref_clk) {timing_load, su, pu, ho, ac} <= {1'b1, s, p, h, a};
    @(posedge ref_clk) timing_load <= 1'b0;
  endtask : load
  task xfer(input logic w, input logic [1:0] sel, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk) {req_valid, req_write, req_select, req_wdata} <= {1'b1, w, sel, d};
    while (resp_valid !== 1'b1 && n < 300) begin
      @(negedge ref_clk) n++;
    end
    @(posedge ref_clk) req_valid <= 1'b0;
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge ref_clk) n++;
    end
    if (n >= 300) cmp("handshake", 1, 0);
  endtask : xfer
  task t_defaults;
    xfer(1'b1, 2'h1, 16'h5A3C);
    {s0, p0, h0} = {twf - tsf, twr - twf, tsr - twr};
    cmp("data drive", 1'b0, doe_seen);
    xfer(1'b0, 2'h1, 16'h0);
    a0 = trv - tsf;
    cmp("data float", 1'b1, doe_seen);
    cmp("flash addr", 24'hABCD02, fa_seen);
    cmp("boot read", 16'h5A3C, rd);
    cmp("ext addr", 2'h2, ext_seen);
    cmp("ext drive", 2'h0, oe_seen);
  endtask : t_defaults
  task t_counts;
    load(5'h05, 5'h04, 5'h06, 5'h0A);
    mdel <= 5'h08;
    xfer(1'b1, 2'h0, 16'h1234);
    cmp("setup", 3, twf - tsf - s0);
    cmp("pulse", 7, p0 - (twr - twf));
    cmp("hold", 4, tsr - twr - h0);
    xfer(1'b0, 2'h0, 16'h0);
    cmp("access", 9, a0 - (trv - tsf));
    cmp("read a", 16'h1234, rd);
  endtask : t_counts
  task t_clamp;
    load(5'h02, 5'h1F, 5'h02, 5'h1F);
    mdel <= 5'h11;
    xfer(1'b1, 2'h2, 16'hC0DE);
    cmp("pulse clamp", 8, twr - twf - p0);
    xfer(1'b0, 2'h2, 16'h0);
    cmp("access clamp", a0, trv - tsf);
    cmp("read c", 16'hC0DE, rd);
    xfer(1'b0, 2'h0, 16'h0);
    cmp("read a", 16'h1234, rd);
  endtask : t_clamp
  task t_refuse_reset;
    int n0;
    n0 = nsel;
    @(posedge ref_clk) {req_valid, req_select} <= {1'b1, 2'h3};
    repeat (6) @(posedge ref_clk);
    cmp("code 3", n0, nsel);
    {req_select, req_write} <= {2'h1, 1'b1};
    repeat (4) @(posedge ref_clk);
    {rst_n, req_valid} <= 2'h0;
    @(posedge ref_clk) {rst_n, ext_enable} <= 2'h2;
    @(negedge ref_clk) cmp("reset idle", 4'hF, {sel_n, we_n});
    xfer(1'b1, 2'h1, 16'h0F0F);
    cmp("setup default", s0, twf - tsf);
    cmp("ext float", 2'h3, oe_seen);
  endtask : t_refuse_reset
  task summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  initial begin
    #100000;
    miscompares++;
    summarize;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    {rst_n, ext_enable} <= 2'h3;
    t_defaults;
    t_counts;
    t_clamp;
    t_refuse_reset;
    summarize;
  end
endmodule : nfpm_port_test
